// ==== rtl/nes_pkg.sv ====
/*
 Package of the flash erase/status host controller: command codes,
 status and ECC field positions, pin timing counts.
 Assumes a 20 MHz core clock and an 8-bit strobed flash bus.
*/
package nes_pkg;
   // ----------------------------------------
   // Commands
   // ----------------------------------------
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
   localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_READ = 8'h00;
   localparam logic [7:0] CMD_ECC_STATUS = 8'h7a;
   // ----------------------------------------
   // Status fields
   // ----------------------------------------
   localparam int ST_PASS_FAIL = 0;
   localparam int ST_CORRECTED = 3;
   localparam int ST_READY = 6;
   localparam int ST_WP_N = 7;
   localparam logic [7:0] ST_USED_MASK = 8'hc9;
   localparam int ECC_CNT_LSB = 0;
   localparam int ECC_SEC_LSB = 4;
   localparam logic [3:0] ECC_CNT_MAX = 4'h4;
   localparam logic [3:0] ECC_SEC_MAX = 4'h3;
   localparam int ECC_SECTORS = 4;
   // ----------------------------------------
   // Addressing
   // ----------------------------------------
   localparam int ROW_PAGE_BITS = 6;
   localparam int BLOCK_BITS = 10;
   localparam logic [15:0] ROW_PAGE_MASK = 16'hffc0;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int STROBE_NS = 25;
   localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
endpackage : nes_pkg

// ==== rtl/nes_strobe.sv ====
/*
 One strobed bus cycle on the flash pins: write or read.
 Assumes the caller holds start for one cycle while idle.
*/
`timescale 1ns/1ps
module nes_strobe
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic start,
   input wire logic is_read,
   output logic strobe_n,
   output logic active,
   output logic done
);
   typedef struct packed
   {
      logic busy;
      logic [3:0] cnt;
      logic low;
      logic done;
   } nes_stb_type;
   nes_stb_type s_r;
   nes_stb_type s_nxt;
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      if (!s_r.busy)
      begin
         if (start)
         begin
            s_nxt.busy = 1'b1;
            s_nxt.low = 1'b1;
            s_nxt.cnt = nes_pkg::STROBE_CNT;
         end
      end
      else if (s_r.cnt != 4'h0)
      begin
         s_nxt.cnt = s_r.cnt - 4'h1;
      end
      else if (s_r.low)
      begin
         s_nxt.low = 1'b0;
         s_nxt.cnt = nes_pkg::STROBE_CNT;
      end
      else
      begin
         s_nxt.busy = 1'b0;
         s_nxt.done = 1'b1;
      end
   end
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end
   assign strobe_n = ~s_r.low;
   assign active = s_r.busy;
   assign done = s_r.done;
   AST_STROBE_LEN: assert property (@(posedge core_clk) disable iff (!rstn)
      $rose(s_r.low) |-> s_r.low [*2] ##1 !s_r.low)
      else $error("strobe low phase length wrong");
endmodule : nes_strobe

// ==== rtl/nes_host.sv ====
/*
 Host controller for block erase, status and ECC status reads on a
 strobed 8-bit flash bus. Assumes the flash pins are external and async.
*/
`timescale 1ns/1ps
// What this block does
// - Send setup code then two block-address cycles
// - Confirm code always follows address cycles
// - Status code then read cycles drive status
// - Reissue read code after mid-read status
// - Mask unused status bits 1,2,4,5
// - ECC status covers all four sectors
module nes_host
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic erase_req,
   input wire logic [9:0] erase_block,
   input wire logic status_req,
   input wire logic ecc_req,
   input wire logic resume_read,
   output logic cmd_done,
   output logic erase_fail,
   output logic [7:0] status_masked,
   output logic [15:0] ecc_word,
   output logic ecc_bad,
   output logic cle,
   output logic ale,
   output logic ce_n,
   output logic write_strobe_n,
   output logic read_strobe_n,
   output logic [7:0] io_out,
   output logic io_oe,
   input wire logic [7:0] io_in,
   input wire logic ready_busy_n
);
   typedef enum logic [3:0]
   {
      ST_IDLE = 4'b0000, ST_SETUP = 4'b0001, ST_ADDR0 = 4'b0010, ST_ADDR1 = 4'b0011,
      ST_CONFIRM = 4'b0100, ST_WAIT = 4'b0101, ST_STCMD = 4'b0110, ST_STREAD = 4'b0111,
      ST_ECCCMD = 4'b1000, ST_ECCREAD = 4'b1001, ST_RDCMD = 4'b1010, ST_DONE = 4'b1011
   } nes_state_type;
   typedef struct packed
   {
      nes_state_type st;
      logic started;
      logic is_erase;
      logic [1:0] sec;
      logic [15:0] row;
      logic cle;
      logic ale;
      logic ce_n;
      logic [7:0] io;
      logic oe;
      logic done;
      logic fail;
      logic [7:0] status;
      logic [15:0] ecc;
      logic ecc_bad;
   } nes_host_type;
   nes_host_type s_r;
   nes_host_type s_nxt;
   logic [7:0] io_s1_r;
   logic [7:0] io_s2_r;
   logic rb_s1_r;
   logic rb_s2_r;
   logic stb_start;
   logic stb_read;
   logic stb_n;
   logic stb_active;
   logic stb_done;
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         io_s1_r <= 8'h00;
         io_s2_r <= 8'h00;
         rb_s1_r <= 1'b0;
         rb_s2_r <= 1'b0;
      end
      else
      begin
         io_s1_r <= io_in;
         io_s2_r <= io_s1_r;
         rb_s1_r <= ready_busy_n;
         rb_s2_r <= rb_s1_r;
      end
   end
   nes_strobe u_strobe
   (
      .core_clk(core_clk),
      .rstn(rstn),
      .start(stb_start),
      .is_read(stb_read),
      .strobe_n(stb_n),
      .active(stb_active),
      .done(stb_done)
   );
   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      stb_start = 1'b0;
      stb_read = 1'b0;
      if (s_r.st != ST_IDLE && s_r.st != ST_WAIT && s_r.st != ST_DONE && !s_r.started)
      begin
         stb_start = 1'b1;
         stb_read = (s_r.st == ST_STREAD) || (s_r.st == ST_ECCREAD);
         s_nxt.started = 1'b1;
      end
      case (s_r.st)
         ST_IDLE:
         begin
            s_nxt.ce_n = 1'b1;
            s_nxt.oe = 1'b0;
            if (erase_req)
            begin
               s_nxt.row = {erase_block, 6'h00} & nes_pkg::ROW_PAGE_MASK;
               s_nxt.is_erase = 1'b1;
               s_nxt.st = ST_SETUP;
               s_nxt.io = nes_pkg::CMD_ERASE_SETUP;
               s_nxt.cle = 1'b1;
               s_nxt.oe = 1'b1;
               s_nxt.ce_n = 1'b0;
            end
            else if (status_req)
            begin
               s_nxt.is_erase = 1'b0;
               s_nxt.st = ST_STCMD;
               s_nxt.io = nes_pkg::CMD_READ_STATUS;
               s_nxt.cle = 1'b1;
               s_nxt.oe = 1'b1;
               s_nxt.ce_n = 1'b0;
            end
            else if (ecc_req)
            begin
               s_nxt.st = ST_ECCCMD;
               s_nxt.sec = 2'b00;
               s_nxt.ecc_bad = 1'b0;
               s_nxt.io = nes_pkg::CMD_ECC_STATUS;
               s_nxt.cle = 1'b1;
               s_nxt.oe = 1'b1;
               s_nxt.ce_n = 1'b0;
            end
         end
         ST_SETUP, ST_ADDR0, ST_ADDR1, ST_CONFIRM, ST_STCMD, ST_ECCCMD, ST_RDCMD:
         begin
            if (stb_done)
            begin
               s_nxt.started = 1'b0;
               s_nxt.cle = 1'b0;
               s_nxt.ale = 1'b0;
               if (s_r.st == ST_SETUP)
               begin
                  s_nxt.st = ST_ADDR0;
                  s_nxt.ale = 1'b1;
                  s_nxt.io = s_r.row[7:0];
               end
               else if (s_r.st == ST_ADDR0)
               begin
                  s_nxt.st = ST_ADDR1;
                  s_nxt.ale = 1'b1;
                  s_nxt.io = s_r.row[15:8];
               end
               else if (s_r.st == ST_ADDR1)
               begin
                  s_nxt.st = ST_CONFIRM;
                  s_nxt.cle = 1'b1;
                  s_nxt.io = nes_pkg::CMD_ERASE_CONFIRM;
               end
               else if (s_r.st == ST_CONFIRM)
               begin
                  s_nxt.st = ST_WAIT;
                  s_nxt.oe = 1'b0;
               end
               else if (s_r.st == ST_STCMD)
               begin
                  s_nxt.st = ST_STREAD;
                  s_nxt.oe = 1'b0;
               end
               else if (s_r.st == ST_ECCCMD)
               begin
                  s_nxt.st = ST_ECCREAD;
                  s_nxt.oe = 1'b0;
               end
               else
               begin
                  s_nxt.st = ST_DONE;
                  s_nxt.oe = 1'b0;
               end
            end
         end
         ST_WAIT:
         begin
            if (rb_s2_r)
            begin
               s_nxt.st = ST_STCMD;
               s_nxt.io = nes_pkg::CMD_READ_STATUS;
               s_nxt.cle = 1'b1;
               s_nxt.oe = 1'b1;
            end
         end
         ST_STREAD:
         begin
            if (stb_done)
            begin
               s_nxt.started = 1'b0;
               s_nxt.status = io_s2_r & nes_pkg::ST_USED_MASK;
               if (s_r.is_erase && !io_s2_r[nes_pkg::ST_READY])
               begin
                  s_nxt.st = ST_STREAD;
               end
               else
               begin
                  if (s_r.is_erase)
                  begin
                     s_nxt.fail = io_s2_r[nes_pkg::ST_PASS_FAIL];
                  end
                  if (resume_read)
                  begin
                     s_nxt.st = ST_RDCMD;
                     s_nxt.io = nes_pkg::CMD_READ;
                     s_nxt.cle = 1'b1;
                     s_nxt.oe = 1'b1;
                  end
                  else
                  begin
                     s_nxt.st = ST_DONE;
                  end
               end
            end
         end
         ST_ECCREAD:
         begin
            if (stb_done)
            begin
               s_nxt.started = 1'b0;
               s_nxt.ecc[s_r.sec*4 +: 4] = io_s2_r[3:0];
               if (io_s2_r[3:0] > nes_pkg::ECC_CNT_MAX || io_s2_r[7:4] > nes_pkg::ECC_SEC_MAX)
               begin
                  s_nxt.ecc_bad = 1'b1;
               end
               s_nxt.sec = s_r.sec + 2'b01;
               if (s_r.sec == 2'b11)
               begin
                  s_nxt.st = ST_DONE;
               end
            end
         end
         ST_DONE:
         begin
            s_nxt.done = 1'b1;
            s_nxt.ce_n = 1'b1;
            s_nxt.st = ST_IDLE;
         end
         default:
         begin
            s_nxt.st = ST_IDLE;
         end
      endcase
   end
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_r <= '0;
         s_r.ce_n <= 1'b1;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end
   // ----------------------------------------
   // Pin and user outputs
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         write_strobe_n <= 1'b1;
         read_strobe_n <= 1'b1;
      end
      else
      begin
         write_strobe_n <= stb_n | ~stb_active | ~s_r.oe;
         read_strobe_n <= stb_n | ~stb_active | s_r.oe;
      end
   end
   assign cle = s_r.cle;
   assign ale = s_r.ale;
   assign ce_n = s_r.ce_n;
   assign io_out = s_r.io;
   assign io_oe = s_r.oe;
   assign cmd_done = s_r.done;
   assign erase_fail = s_r.fail;
   assign status_masked = s_r.status;
   assign ecc_word = s_r.ecc;
   assign ecc_bad = s_r.ecc_bad;
   sequence seq_confirm;
      s_r.st == ST_ADDR1 ##1 s_r.st == ST_CONFIRM;
   endsequence
   AST_CONFIRM_ORDER: assert property (@(posedge core_clk) disable iff (!rstn)
      $rose(s_r.st == ST_CONFIRM) |-> $past(s_r.st) == ST_ADDR1)
      else $error("confirm without address cycles");
   AST_SETUP_CODE: assert property (@(posedge core_clk) disable iff (!rstn)
      s_r.st == ST_SETUP |-> s_r.io == nes_pkg::CMD_ERASE_SETUP && s_r.cle)
      else $error("setup code wrong");
   AST_PAGE_ZERO: assert property (@(posedge core_clk) disable iff (!rstn)
      s_r.st == ST_ADDR0 |-> s_r.io[5:0] == 6'h00)
      else $error("page bits not cleared");
   AST_MASK: assert property (@(posedge core_clk) disable iff (!rstn)
      (s_r.status & ~nes_pkg::ST_USED_MASK) == 8'h00)
      else $error("unused status bits leak");
   AST_WAIT_RB: assert property (@(posedge core_clk) disable iff (!rstn)
      s_r.st == ST_WAIT && !rb_s2_r |=> s_r.st == ST_WAIT)
      else $error("left wait while busy");
endmodule : nes_host

// ==== bench/nes_flash_model.sv ====
/*
 Behavioural flash device: block erase, status and ECC status reads.
 Assumes the host pins of nes_host; no clock, busy time given in ns.
*/
`timescale 1ns/1ps
module nes_flash_model
(
   input wire logic cle,
   input wire logic ale,
   input wire logic ce_n,
   input wire logic write_strobe_n,
   input wire logic read_strobe_n,
   input wire logic [7:0] io_out,
   input wire logic fail_set,
   input wire logic corr_set,
   input wire logic wp_n_set,
   input wire logic [15:0] ecc_set,
   input wire logic [15:0] busy_ns,
   output logic [7:0] io_in,
   output logic ready_busy_n
);
   logic [7:0] cmd_r, last_r, junk, addr0, status;
   logic [9:0] blk_r;
   logic [1:0] addr_cnt, ecc_idx;
   logic setup_r, fail_r;
   int erase_cnt;
   event erase_go;
   // ----------------------------------------
   // Command and address latch
   // ----------------------------------------
   initial
   begin
      {cmd_r, last_r, junk, addr0, blk_r, addr_cnt, ecc_idx, setup_r, fail_r} = '0;
      erase_cnt = 0;
      ready_busy_n = 1'b1;
   end
   always @(posedge write_strobe_n)
   begin
      if (!ce_n && cle)
      begin
         if (io_out === nes_pkg::CMD_ERASE_CONFIRM && setup_r && addr_cnt == 2'd2)
            -> erase_go;
         setup_r = (io_out === nes_pkg::CMD_ERASE_SETUP);
         cmd_r = io_out;
         addr_cnt = '0;
         ecc_idx = '0;
      end
      else if (!ce_n && ale && addr_cnt < 2'd2)
      begin
         if (addr_cnt == 2'd0)
            addr0 = io_out;
         else
            blk_r = {io_out, addr0[7:6]};
         addr_cnt = addr_cnt + 2'd1;
      end
   end
   always @(erase_go)
   begin
      ready_busy_n = 1'b0;
      #(busy_ns);
      fail_r = fail_set;
      erase_cnt = erase_cnt + 1;
      ready_busy_n = 1'b1;
   end
   // ----------------------------------------
   // Read output
   // ----------------------------------------
   // status fields
   assign status = {wp_n_set, ready_busy_n, junk[5:4], corr_set, junk[2:1], fail_r};
   always @*
   begin
      if (ce_n || read_strobe_n)
         io_in = ~last_r;
      else if (cmd_r === nes_pkg::CMD_ECC_STATUS)
         io_in = {2'b00, ecc_idx, ecc_set[4 * ecc_idx +: 4]};
      else
         io_in = status;
   end
   always @(io_in)
      if (!ce_n && !read_strobe_n)
         last_r = io_in;
   always @(negedge read_strobe_n)
      junk = 8'($urandom);
   always @(posedge read_strobe_n)
      if (!ce_n && cmd_r === nes_pkg::CMD_ECC_STATUS)
         ecc_idx = ecc_idx + 2'd1;
endmodule : nes_flash_model

// ==== bench/tb_nes_host.sv ====
/*
 Self-checking bench of nes_host against the flash model.
 Assumes a 50 ns clock; expected results wait in a queue.
*/
`timescale 1ns/1ps
module tb_nes_host;
   typedef struct {
      logic [7:0] st;
      logic fail;
      logic [15:0] ecc;
      logic bad;
      logic [7:0] cmd;
      logic [9:0] blk;
      int cnt;
   } nes_exp_type;
   logic core_clk, rstn, erase_req, status_req, ecc_req, resume_read;
   logic cmd_done, erase_fail, ecc_bad, cle, ale, ce_n, write_strobe_n, read_strobe_n, io_oe, ready_busy_n;
   logic fail_set, corr_set, wp_n_set;
   logic [9:0] erase_block;
   logic [7:0] status_masked, io_out, io_in;
   logic [15:0] ecc_word, ecc_set, busy_ns;
   nes_exp_type exp_q[$];
   nes_exp_type e, x;
   int error_cnt = 0;
   int check_count = 0;
   nes_host nes_host_i (.core_clk, .rstn, .erase_req, .erase_block, .status_req, .ecc_req, .resume_read,
      .cmd_done, .erase_fail, .status_masked, .ecc_word, .ecc_bad, .cle, .ale, .ce_n, .write_strobe_n,
      .read_strobe_n, .io_out, .io_oe, .io_in, .ready_busy_n);
   nes_flash_model nes_flash_model_i (.cle, .ale, .ce_n, .write_strobe_n, .read_strobe_n, .io_out,
      .fail_set, .corr_set, .wp_n_set, .ecc_set, .busy_ns, .io_in, .ready_busy_n);
   always #25 core_clk = ~core_clk;
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done();
      if (error_cnt == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done
   task automatic run(input int kind);
      int n;
      n = 0;
      @(posedge core_clk);
      #2;
      erase_req = (kind == 0);
      status_req = (kind == 1);
      ecc_req = (kind == 2);
      @(posedge core_clk);
      #2;
      {erase_req, status_req, ecc_req} = '0;
      while (cmd_done !== 1'b1 && n < 4000)
      begin
         @(negedge core_clk);
         n++;
      end
      if (n == 4000)
      begin
         error_cnt++;
         $display("MISMATCH %0t no completion", $time);
      end
      @(posedge core_clk);
   endtask : run
   // ----------------------------------------
   // Result monitor
   // ----------------------------------------
   always @(negedge core_clk)
   begin
      if (cmd_done === 1'b1 && exp_q.size() > 0)
      begin
         e = exp_q.pop_front();
         check(16'(status_masked), 16'(e.st));
         check(16'(erase_fail), 16'(e.fail));
         check(ecc_word, e.ecc);
         check(16'(ecc_bad), 16'(e.bad));
         check(16'(nes_flash_model_i.cmd_r), 16'(e.cmd));
         check(16'(nes_flash_model_i.blk_r), 16'(e.blk));
         check(16'(nes_flash_model_i.erase_cnt), 16'(e.cnt));
      end
      else if (cmd_done === 1'b1)
         check(16'h1, 16'h0);
   end
   // ----------------------------------------
   // Stimulus
   // ----------------------------------------
   initial
   begin
      core_clk = 1'b0;
      rstn = 1'b0;
      {erase_req, status_req, ecc_req, resume_read, fail_set, corr_set} = '0;
      wp_n_set = 1'b1;
      erase_block = '0;
      ecc_set = '0;
      busy_ns = 16'd300;
      x = '{default: '0};
      void'($urandom(32'h0d00));
      repeat (3) @(posedge core_clk);
      #2;
      rstn = 1'b1;
      for (int i = 0; i < 15; i++)
      begin
         #2;
         fail_set = 1'($urandom);
         corr_set = 1'($urandom);
         wp_n_set = 1'($urandom);
         busy_ns = 16'($urandom_range(2000, 60));
         resume_read = (i % 3 == 1) && 1'($urandom);
         erase_block = (i == 0) ? 10'h3ff : (i == 3) ? 10'h000 : 10'($urandom);
         for (int s = 0; s < 4; s++)
            ecc_set[4 * s +: 4] = 4'($urandom_range(4, 0));
         if (i == 14)
            ecc_set[7:4] = 4'h5;
         if (i % 3 == 0)
         begin
            x.fail = fail_set;
            x.blk = erase_block;
            x.cnt++;
         end
         if (i % 3 == 2)
         begin
            x.ecc = ecc_set;
            x.bad = (i == 14);
            x.cmd = nes_pkg::CMD_ECC_STATUS;
         end
         else
         begin
            x.st = {wp_n_set, 1'b1, 2'b00, corr_set, 2'b00, x.fail};
            x.cmd = resume_read ? nes_pkg::CMD_READ : nes_pkg::CMD_READ_STATUS;
         end
         exp_q.push_back(x);
         run(i % 3);
      end
      check(16'(exp_q.size()), 16'h0);
      test_done();
   end
   initial
   begin
      #(50 * 40000);
      error_cnt++;
      test_done();
   end
endmodule : tb_nes_host
